// file: common/pioreg_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts of the PIO
 * read-pointer register pair. Assumes byte addressing on a 32-bit APB.
 */
// How it works
// - Bits 17:16 pick one of four banks
// - Bank select steers PIO accesses, never DMA
// - Bits 15:0 give the incrementing read start
// - Start address used by PIO reads only
// - Bits 31:24 of shaping register: minimum width
// - Bank pointer latched, then incremented per read
// - Edge interrupts spaced by microframes; zero immediate
`ifndef PIOREG_CFG_SVH
`define PIOREG_CFG_SVH
// ***************************
// Register map
// ***************************
`define PIOREG_PTR_OFS 12'h33C
`define PIOREG_IRQ_OFS 12'h340
`define PIOREG_BANK_LSB 16
`define PIOREG_BANK_MSB 17
`define PIOREG_ADDR_MSB 15
`define PIOREG_MINW_LSB 24
`define PIOREG_MINW_MSB 31
`define PIOREG_BANK_RST 2'h0
`define PIOREG_ADDR_RST 16'h0000
`define PIOREG_MINW_RST 8'h00
// ***************************
// Timing
// ***************************
`define PIOREG_PCLK_NS 4
`define PIOREG_UFRAME_NS 125000
`define PIOREG_UFRAME_CYC ((`PIOREG_UFRAME_NS + `PIOREG_PCLK_NS - 1) / `PIOREG_PCLK_NS)
`endif

// file: common/pioreg_pkg.sv
/*
 * Types shared by the PIO read-pointer block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package pioreg_pkg;
   typedef logic [1:0] pioreg_bank_t;
   typedef logic [15:0] pioreg_addr_t;
   typedef logic [7:0] pioreg_minw_t;
   // Gray coded: only one bit changes on each transition
   typedef enum logic [1:0] {
      PIOREG_IDLE = 2'b00,
      PIOREG_HOLD = 2'b01
   } pioreg_spc_e;
endpackage
`default_nettype wire

// file: src/pioreg_bank_ptr.sv
/*
 * One bank's read pointer: loads a start address, steps on each read.
 * Assumes load and step are one-cycle strobes on pclk.
 */
`default_nettype none
`include "pioreg_cfg.svh"
module pioreg_bank_ptr (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Control
   input wire logic load,
   input wire pioreg_pkg::pioreg_addr_t load_val,
   input wire logic step,
   // State
   output pioreg_pkg::pioreg_addr_t ptr_ff
);
   import pioreg_pkg::*;
   pioreg_addr_t nxt_ptr;

   always_comb begin
      nxt_ptr = ptr_ff;
      // A new address wins over a read in the same cycle
      if (load) begin
         nxt_ptr = load_val;
      end else if (step) begin
         nxt_ptr = ptr_ff + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr_ff <= `PIOREG_ADDR_RST;
      end else if (ce) begin
         ptr_ff <= nxt_ptr;
      end
   end
endmodule
`default_nettype wire

// file: src/pioreg_top.sv
/*
 * PIO read-pointer and edge-interrupt shaping registers behind APB.
 * Assumes PIO strobes and interrupt events come from logic on pclk.
 */
// Decided for this implementation: register access over APB.
`default_nettype none
`include "pioreg_cfg.svh"
module pioreg_top #(
   parameter int ADDR_W = 12,
   parameter int NBANK = 4,
   parameter int UF_CYC = `PIOREG_UFRAME_CYC
) (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata_ff,
   output logic pready_ff,
   output logic pslverr_ff,
   // PIO memory access
   input wire logic pio_rd_req,
   input wire logic pio_wr_req,
   output pioreg_pkg::pioreg_bank_t pio_bank_ff,
   output pioreg_pkg::pioreg_addr_t pio_rd_addr_ff,
   output logic pio_rd_vld_ff,
   // Interrupts
   input wire logic irq_event,
   input wire logic irq_level,
   output logic irq_edge_ff,
   output logic irq_level_ff
);
   import pioreg_pkg::*;

   // ***************************
   // APB decode
   // ***************************
   pioreg_bank_t bank_sel_ff, nxt_bank_sel;
   pioreg_minw_t minw_ff, nxt_minw;
   logic [31:0] nxt_prdata;
   logic nxt_pready, nxt_pslverr;
   logic hit_ptr, hit_irq, take_wr;
   logic [31:0] ptr_val, irq_val, wmerge;
   pioreg_addr_t ptr_q [NBANK];
   logic [NBANK-1:0] load_v, step_v;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   assign hit_ptr = (paddr == `PIOREG_PTR_OFS);
   assign hit_irq = (paddr == `PIOREG_IRQ_OFS);
   // Reserved bits read back as zero; the minimum-width field lives in the shaping register
   assign ptr_val = {14'h0000, bank_sel_ff, ptr_q[bank_sel_ff]};
   assign irq_val = {minw_ff, 24'h000000};
   // Commit at the edge where pready is seen high
   assign take_wr = psel && penable && pready_ff && pwrite;
   assign wmerge = merge(hit_ptr ? ptr_val : irq_val, pwdata, pstrb);

   always_comb begin
      nxt_pready = psel && penable && !pready_ff;
      nxt_pslverr = psel && penable && !pready_ff && !(hit_ptr || hit_irq);
      nxt_prdata = 32'h00000000;
      if (psel && penable && !pready_ff && !pwrite) begin
         if (hit_ptr) begin
            nxt_prdata = ptr_val;
         end else if (hit_irq) begin
            nxt_prdata = irq_val;
         end
      end
      nxt_bank_sel = bank_sel_ff;
      nxt_minw = minw_ff;
      load_v = '0;
      if (take_wr && hit_ptr) begin
         nxt_bank_sel = wmerge[`PIOREG_BANK_MSB:`PIOREG_BANK_LSB];
         // Only address lanes touched reload the pointer
         if (pstrb[1:0] != 2'b00) begin
            load_v[wmerge[`PIOREG_BANK_MSB:`PIOREG_BANK_LSB]] = 1'b1;
         end
      end else if (take_wr && hit_irq) begin
         nxt_minw = wmerge[`PIOREG_MINW_MSB:`PIOREG_MINW_LSB];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h00000000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         bank_sel_ff <= `PIOREG_BANK_RST;
         minw_ff <= `PIOREG_MINW_RST;
      end else if (ce) begin
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         bank_sel_ff <= nxt_bank_sel;
         minw_ff <= nxt_minw;
      end
   end

   // ***************************
   // Bank pointers
   // ***************************
   pioreg_bank_t nxt_pio_bank;
   pioreg_addr_t nxt_rd_addr;
   logic nxt_rd_vld;

   for (genvar b = 0; b < NBANK; b++) begin : g_bank
      assign step_v[b] = pio_rd_req && (bank_sel_ff == pioreg_bank_t'(b));
      pioreg_bank_ptr u_ptr (
         .pclk(pclk),
         .presetn(presetn),
         .ce(ce),
         .load(load_v[b]),
         .load_val(wmerge[`PIOREG_ADDR_MSB:0]),
         .step(step_v[b]),
         .ptr_ff(ptr_q[b])
      );
   end

   always_comb begin
      nxt_pio_bank = pio_bank_ff;
      nxt_rd_addr = pio_rd_addr_ff;
      nxt_rd_vld = 1'b0;
      // DMA has no path in here, so the selector cannot steer it
      if (pio_rd_req || pio_wr_req) begin
         nxt_pio_bank = bank_sel_ff;
      end
      if (pio_rd_req) begin
         nxt_rd_addr = ptr_q[bank_sel_ff];
         nxt_rd_vld = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pio_bank_ff <= `PIOREG_BANK_RST;
         pio_rd_addr_ff <= `PIOREG_ADDR_RST;
         pio_rd_vld_ff <= 1'b0;
      end else if (ce) begin
         pio_bank_ff <= nxt_pio_bank;
         pio_rd_addr_ff <= nxt_rd_addr;
         pio_rd_vld_ff <= nxt_rd_vld;
      end
   end

   // ***************************
   // Edge interrupt spacing
   // ***************************
   pioreg_spc_e spc_ff, nxt_spc;
   logic [$clog2(UF_CYC+1)-1:0] tick_ff, nxt_tick;
   pioreg_minw_t left_ff, nxt_left;
   logic pend_ff, nxt_pend, nxt_irq_edge, fire;

   always_comb begin
      nxt_spc = spc_ff;
      nxt_tick = tick_ff;
      nxt_left = left_ff;
      nxt_irq_edge = 1'b0;
      // A held-off event stays pending until the gap has passed
      nxt_pend = pend_ff || irq_event;
      fire = 1'b0;
      case (spc_ff)
         PIOREG_IDLE: begin
            if (irq_event || pend_ff) begin
               fire = 1'b1;
            end
         end
         PIOREG_HOLD: begin
            if (tick_ff == ($bits(tick_ff))'(UF_CYC - 1)) begin
               nxt_tick = '0;
               nxt_left = left_ff - 8'h01;
               if (left_ff == 8'h01) begin
                  nxt_spc = PIOREG_IDLE;
               end
            end else begin
               nxt_tick = tick_ff + 1'b1;
            end
         end
         default: nxt_spc = PIOREG_IDLE;
      endcase
      if (fire) begin
         nxt_irq_edge = 1'b1;
         nxt_pend = 1'b0;
         nxt_tick = '0;
         nxt_left = minw_ff;
         if (minw_ff != 8'h00) begin
            nxt_spc = PIOREG_HOLD;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         spc_ff <= PIOREG_IDLE;
         tick_ff <= '0;
         left_ff <= 8'h00;
         pend_ff <= 1'b0;
         irq_edge_ff <= 1'b0;
         irq_level_ff <= 1'b0;
      end else if (ce) begin
         spc_ff <= nxt_spc;
         tick_ff <= nxt_tick;
         left_ff <= nxt_left;
         pend_ff <= nxt_pend;
         irq_edge_ff <= nxt_irq_edge;
         irq_level_ff <= irq_level;
      end
   end

   // ***************************
   // Assertions
   // ***************************
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn || !ce);

   bank_field_a: assert property (take_wr && hit_ptr && pstrb[2] |=> bank_sel_ff == $past(pwdata[17:16]))
      else $error("bank selector not taken from write");
   pio_bank_a: assert property (pio_wr_req && !take_wr |=> pio_bank_ff == $past(bank_sel_ff))
      else $error("pio bank not the selected bank");
   start_addr_a: assert property (take_wr && hit_ptr && pstrb == 4'hF ##1 !pio_rd_req |=>
      pio_rd_vld_ff == 1'b0 && ptr_q[$past(pwdata[17:16], 2)] == $past(pwdata[15:0], 2))
      else $error("start address not latched");
   rd_addr_a: assert property (pio_rd_req |=> pio_rd_vld_ff && pio_rd_addr_ff == $past(ptr_q[bank_sel_ff]))
      else $error("read address not the bank pointer");
   wr_hold_a: assert property (pio_wr_req && !pio_rd_req && !take_wr |=>
      ptr_q[$past(bank_sel_ff)] == $past(ptr_q[bank_sel_ff]))
      else $error("write moved the read pointer");
   min_width_a: assert property (take_wr && hit_irq && pstrb[3] |=> minw_ff == $past(pwdata[31:24]))
      else $error("minimum width not written");
   rd_step_a: assert property (pio_rd_req && !take_wr |=>
      ptr_q[$past(bank_sel_ff)] == $past(ptr_q[bank_sel_ff]) + 16'h0001)
      else $error("pointer did not step on read");
   // Width is latched when the pulse is launched, one cycle before it shows
   spacing_a: assert property (irq_edge_ff && $past(minw_ff) != 8'h00 |=> !irq_edge_ff [*8])
      else $error("edge interrupts too close");
   level_pass_a: assert property (1'b1 |=> irq_level_ff == $past(irq_level))
      else $error("level interrupt was shaped");
   immediate_a: assert property (minw_ff == 8'h00 && spc_ff == PIOREG_IDLE && irq_event |=> irq_edge_ff)
      else $error("zero width did not fire at once");

   wr_ptr_c: cover property (take_wr && hit_ptr);
   rd_run_c: cover property (pio_rd_req ##1 pio_rd_req ##1 pio_rd_req);
   held_c: cover property (spc_ff == PIOREG_HOLD && irq_event);
endmodule
`default_nettype wire

// file: tb/pioreg_pio_model.sv
/*
 * Far-side logic that registers bench commands into PIO read and write strobes, one cycle per command cycle.
 * Assumes the bench commands it from the pclk domain.
 */
`default_nettype none
module pioreg_pio_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Commands from the bench
   input wire logic rd_cmd,
   input wire logic wr_cmd,
   // Strobes to the block
   output logic pio_rd_req,
   output logic pio_wr_req
);
   timeunit 1ns;
   timeprecision 1ps;
   // Registered so that strobes always leave on a clean edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pio_rd_req <= 1'b0;
         pio_wr_req <= 1'b0;
      end else begin
         pio_rd_req <= rd_cmd;
         pio_wr_req <= wr_cmd;
      end
   end
endmodule
`default_nettype wire

// file: tb/testbench.sv
/*
 * Self-checking bench for the PIO pointer block over APB.
 * Assumes UF_CYC shortened to 10 cycles for the spacing check.
 */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, irq_event = 0, irq_level = 0;
   logic rd_cmd = 0, wr_cmd = 0, pio_rd_req, pio_wr_req, pio_rd_vld_ff;
   logic pready_ff, pslverr_ff, irq_edge_ff, irq_level_ff;
   logic [11:0] paddr = '0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] pwdata = '0, prdata_ff;
   pioreg_pkg::pioreg_bank_t pio_bank_ff;
   pioreg_pkg::pioreg_addr_t pio_rd_addr_ff;
   logic [32:0] q_apb[$];
   logic [32:0] q_pio[$];
   int n_errors = 0, checked = 0, seed = 37, n_irq = 0;
   logic [15:0] a;
   always #2 pclk = ~pclk;
   pioreg_top #(.UF_CYC(10)) u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .pio_rd_req(pio_rd_req),
      .pio_wr_req(pio_wr_req), .pio_bank_ff(pio_bank_ff), .pio_rd_addr_ff(pio_rd_addr_ff),
      .pio_rd_vld_ff(pio_rd_vld_ff), .irq_event(irq_event), .irq_level(irq_level),
      .irq_edge_ff(irq_edge_ff), .irq_level_ff(irq_level_ff));
   pioreg_pio_model u_pio (.pclk(pclk), .presetn(presetn), .rd_cmd(rd_cmd), .wr_cmd(wr_cmd),
      .pio_rd_req(pio_rd_req), .pio_wr_req(pio_wr_req));
   // ***************************
   // Tasks
   // ***************************
   task automatic cmp(input logic [32:0] e, input logic [32:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("Error at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready_ff !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] ad, input logic [32:0] e);
      q_apb.push_back(e);
      apb(1'b0, ad, 32'h0, 4'h0);
   endtask
   task automatic after(input int n, input int e);
      repeat (n) @(posedge pclk);
      #1 cmp(33'(e), 33'(n_irq));
   endtask
   task automatic irq2(input int n, input int e);
      @(posedge pclk) irq_event <= 1'b1;
      repeat (2) @(posedge pclk);
      irq_event <= 1'b0;
      after(n, e);
   endtask
   task automatic lvl(input logic v);
      @(posedge pclk) irq_level <= v;
      repeat (2) @(posedge pclk);
      #1 cmp(33'(v), 33'(irq_level_ff));
   endtask
   task automatic wrap_up;
      $display("Checks: %0d, errors: %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ***************************
   // Monitors
   // ***************************
   always @(posedge pclk) begin
      if (pready_ff === 1'b1 && pwrite === 1'b0) begin
         cmp(q_apb.size() ? q_apb.pop_front() : 'x, {pslverr_ff, prdata_ff});
      end
      if (pio_rd_vld_ff === 1'b1) begin
         cmp(q_pio.size() ? q_pio.pop_front() : 'x, {15'h0, pio_bank_ff, pio_rd_addr_ff});
      end
      if (irq_edge_ff === 1'b1) begin
         n_irq++;
      end
   end
   initial begin
      #40000;
      n_errors++;
      wrap_up;
   end
   // ***************************
   // Stimulus
   // ***************************
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h33C, 33'h0);
      rd(12'h340, 33'h0);
      rd(12'h344, {1'b1, 32'h0});
      a = 16'($random(seed));
      apb(1'b1, 12'h33C, {14'h0, 2'h2, a}, 4'hF);
      rd(12'h33C, {17'h2, a});
      q_pio.push_back({17'h2, a});
      q_pio.push_back({17'h2, a + 16'h1});
      @(posedge pclk) rd_cmd <= 1'b1;
      repeat (2) @(posedge pclk);
      rd_cmd <= 1'b0;
      wr_cmd <= 1'b1;
      @(posedge pclk) wr_cmd <= 1'b0;
      rd(12'h33C, {17'h2, a + 16'h2});
      apb(1'b1, 12'h33C, {14'h0, 2'h1, 16'hFFFF}, 4'hF);
      q_pio.push_back({17'h1, 16'hFFFF});
      @(posedge pclk) rd_cmd <= 1'b1;
      @(posedge pclk) rd_cmd <= 1'b0;
      rd(12'h33C, {17'h1, 16'h0000});
      apb(1'b1, 12'h33C, {14'h0, 2'h2, 16'h0}, 4'h4);
      rd(12'h33C, {17'h2, a + 16'h2});
      irq2(4, 2);
      apb(1'b1, 12'h340, 32'h0100_0000, 4'hF);
      rd(12'h340, 33'h0_0100_0000);
      irq2(4, 3);
      lvl(1'b1);
      lvl(1'b0);
      after(14, 4);
      wrap_up;
   end
endmodule
`default_nettype wire
